// file: dv/frame_sync_checker.sv
// Assertion checker for the sync configuration block.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_consts.svh"

module frame_sync_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sources
	input wire frame_sync_pkg::dpll_sync_s primary_dpll_sync,
	input wire frame_sync_pkg::dpll_sync_s secondary_dpll_sync,
	input wire logic width_ref_enabled,
	input wire logic ref_is_19m44,
	// Outputs
	input wire logic frame_sync_output,
	input wire logic multiframe_sync_output,
	input wire logic sync_outputs_unaligned,
	input wire logic ocn_realign_enable,
	input wire frame_sync_pkg::sampling_precision_e sync_sampling_precision,
	// External sync sample results
	input wire logic ext_sync_sample,
	input wire logic ext_sync_fall
);
	localparam logic [11:0] A_P = {`IDX_SYNC_PULSE_CFG, 2'b00};
	localparam logic [11:0] A_A = {`IDX_SYNC_ALIGN_CFG, 2'b00};
	localparam logic [11:0] A_S = {`IDX_SYNC_STATUS, 2'b00};
	logic [7:0] ps_r;
	logic [7:0] as_r;
	logic [2:0] quiet_r;
	logic [2:0] doff_r;
	logic commit, mapped, src8, src2;

	// ==========================================================
	// Shadow of the registers and settle counters
	assign commit = psel && penable && pready && pwrite;
	assign mapped = paddr == A_P || paddr == A_A || paddr == A_S;
	assign src8 = ps_r[7] ? secondary_dpll_sync.sq_8k : primary_dpll_sync.sq_8k;
	assign src2 = ps_r[7] ? secondary_dpll_sync.sq_2k : primary_dpll_sync.sq_2k;
	// Counters saturate, so long quiet spells never wrap
	always_ff @(posedge clk) begin
		if (rst) begin
			ps_r <= 8'h00;
			as_r <= 8'h00;
			quiet_r <= 3'h0;
			doff_r <= 3'h0;
		end else begin
			if (commit && paddr == A_P)
				ps_r <= pwdata[7:0] & `MASK_SYNC_PULSE_CFG;
			if (commit && paddr == A_A)
				as_r <= pwdata[7:0] & `MASK_SYNC_ALIGN_CFG;
			quiet_r <= commit ? 3'h0 : (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
			doff_r <= width_ref_enabled ? 3'h0 : (doff_r == 3'h7 ? doff_r : doff_r + 3'h1);
		end
	end

	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence setup_s;
		psel && !penable;
	endsequence
	rdy_wait_a: assert property (setup_s |=> pready && pslverr == !$past(mapped))
		else $error("pready or pslverr wrong after setup");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_zero_a: assert property ((setup_s and (!mapped && !pwrite)) |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	rd_zero_a: assert property (pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0
		&& (paddr != A_P || prdata[6:4] == 3'h0) && (paddr != A_A || prdata[5:0] == 6'h00))
		else $error("unused bits read nonzero");
	rd_back_a: assert property (pready && !pwrite && paddr == A_P |-> prdata[7:0] == ps_r)
		else $error("pulse register readback wrong");
	ctl_copy_a: assert property (quiet_r >= 3'h2 |-> sync_outputs_unaligned == as_r[7]
		&& ocn_realign_enable == as_r[6])
		else $error("alignment controls wrong");
	prec_sel_a: assert property (quiet_r >= 3'h2 && $stable(ref_is_19m44)
		|-> sync_sampling_precision == (!as_r[6] ? frame_sync_pkg::PREC_6M48
		: ref_is_19m44 ? frame_sync_pkg::PREC_19M44 : frame_sync_pkg::PREC_38M88))
		else $error("sampling precision wrong");
	pulse_off_a: assert property (quiet_r >= 3'h4 && doff_r >= 3'h4
		|-> (!ps_r[2] || frame_sync_output == ps_r[3])
		&& (!ps_r[0] || multiframe_sync_output == ps_r[1]))
		else $error("pulse without enabled reference");
	square_dly_a: assert property (quiet_r >= 3'h4 && as_r[7]
		|-> (ps_r[2] || frame_sync_output == ($past(src8, 2) ^ ps_r[3]))
		&& (ps_r[0] || multiframe_sync_output == ($past(src2, 2) ^ ps_r[1])))
		else $error("independent square output wrong");
	// Fall flag must mark exactly the samples where the captured level drops
	ext_fall_a: assert property (ext_sync_fall == $fell(ext_sync_sample))
		else $error("external sync fall flag wrong");
endmodule

`default_nettype wire

// file: dv/frame_sync_pulse_config_tb_top.sv
// Self-checking bench for the sync configuration block.
// Assumes the checker and the sink model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_consts.svh"

module frame_sync_pulse_config_tb_top;
	localparam logic [11:0] A_P = {`IDX_SYNC_PULSE_CFG, 2'b00};
	localparam logic [11:0] A_A = {`IDX_SYNC_ALIGN_CFG, 2'b00};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic ref_en = 1'b1;
	logic ref19 = 1'b0;
	logic [15:0] cyc = 16'h0000;
	logic [2:0] wc = 3'h0;
	logic [5:0] sc = 6'h00;
	logic [31:0] prdata, rd;
	logic pready, pslverr, fso, mso, unal, ocn, err;
	logic [15:0] w8, w2;
	frame_sync_pkg::sampling_precision_e prec;
	frame_sync_pkg::dpll_sync_s pri, sec;
	int n_fail = 0;
	int tests_run = 0;
	// Rows: pulse write, align write, reference, expected readbacks, precision
	logic [7:0] pw [4] = '{8'hFF, 8'h70, 8'h8A, 8'h05};
	logic [7:0] aw [4] = '{8'hFF, 8'h3F, 8'h40, 8'h80};
	logic r19 [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic [7:0] pe [4] = '{8'h8F, 8'h00, 8'h8A, 8'h05};
	logic [7:0] ae [4] = '{8'hC0, 8'h00, 8'h40, 8'h80};
	logic [1:0] qe [4] = '{2'h1, 2'h0, 2'h2, 2'h0};

	// ==========================================================
	// Clock and sources: secondary half period 24, reference period 6
	always #2 clk = ~clk;
	always_ff @(posedge clk) begin
		cyc <= cyc + 16'h0001;
		wc <= (wc == 3'h5) ? 3'h0 : wc + 3'h1;
		sc <= (sc == 6'h2F) ? 6'h00 : sc + 6'h01;
	end
	assign pri = {cyc[5], cyc[7]};
	assign sec = {sc < 6'h18, cyc[6]};

	frame_sync_pulse_config i_dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primary_dpll_sync(pri), .secondary_dpll_sync(sec),
		.width_reference_output(wc < 3'h3), .width_ref_enabled(ref_en),
		.external_multiframe_sync_input(cyc[8]), .ref_is_19m44(ref19),
		.sample_tick_6m48(cyc[2:0] == 3'h0), .sample_tick_19m44(cyc[1:0] == 2'h0),
		.sample_tick_38m88(cyc[0]), .frame_sync_output(fso), .multiframe_sync_output(mso),
		.sync_outputs_unaligned(unal), .ocn_realign_enable(ocn),
		.sync_sampling_precision(prec), .ext_sync_sample(), .ext_sync_fall()
	);
	sync_sink_model i_sink (.clk(clk), .rst(rst), .frame_in(fso), .mf_in(mso), .w8(w8), .w2(w2));

	// ==========================================================
	// Tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One transfer, left selected so another may follow at once
	// Called idle it aligns to a rising edge; called right after an answer it starts at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		if (!psel) begin
			@(posedge clk);
		end
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (pready !== 1'b1)
			n_fail++;
		rd = prdata;
		err = pslverr;
	endtask
	// Release at the answering edge, then let one edge pass
	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
		idle();
	endtask
	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		idle();
		chk(what, rd, exp);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ref19 <= r19[i];
			wr(A_P, pw[i]);
			wr(A_A, aw[i]);
			rdc("pulse rd", A_P, {24'h0, pe[i]});
			rdc("align rd", A_A, {24'h0, ae[i]});
			@(negedge clk);
			chk("unaligned", {31'h0, unal}, {31'h0, ae[i][7]});
			chk("ocn", {31'h0, ocn}, {31'h0, ae[i][6]});
			chk("precision", {30'h0, prec}, {30'h0, qe[i]});
		end
		// Unmapped place, back to back: error, nothing stored, zero read
		xfer(1'b1, 12'h000, 32'hFF);
		chk("wr err", {31'h0, err}, 32'h1);
		xfer(1'b0, 12'h000, 32'h0);
		idle();
		chk("rd err", {31'h0, err}, 32'h1);
		chk("rd zero", rd, 32'h0);
		rdc("pulse kept", A_P, 32'h05);
		// Back to back writes: secondary source, square, independent
		xfer(1'b1, A_P, 32'h80);
		xfer(1'b1, A_A, 32'h80);
		idle();
		repeat (300) @(negedge clk);
		chk("sec width", {16'h0, w8}, 32'd24);
		wr(A_P, 8'h00);
		repeat (300) @(negedge clk);
		chk("pri width", {16'h0, w8}, 32'd32);
		// Independent pulses, inverted: high time is source period less one reference period
		wr(A_P, 8'h0F);
		repeat (600) @(negedge clk);
		chk("frame pulse", {16'h0, w8}, 32'd58);
		chk("mf pulse", {16'h0, w2}, 32'd250);
		// Aligned pulses: one reference period between two reference edges
		wr(A_A, 8'h00);
		wr(A_P, 8'h05);
		repeat (600) @(negedge clk);
		chk("frame aligned", {16'h0, w8}, 32'd6);
		chk("mf aligned", {16'h0, w2}, 32'd6);
		// Reference disabled: pulses refused, outputs held at flip level
		@(posedge clk);
		ref_en <= 1'b0;
		wr(A_P, 8'h0F);
		repeat (50) @(negedge clk);
		chk("frame off", {31'h0, fso}, 32'h1);
		chk("mf off", {31'h0, mso}, 32'h1);
		// Second reset in mid-run clears both registers
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc("pulse reset", A_P, 32'h0);
		rdc("align reset", A_A, 32'h0);
		chk("unal reset", {31'h0, unal}, 32'h0);
		stop_test();
	end
endmodule

bind frame_sync_pulse_config frame_sync_checker i_chk (
	.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.primary_dpll_sync, .secondary_dpll_sync, .width_ref_enabled, .ref_is_19m44,
	.frame_sync_output, .multiframe_sync_output, .sync_outputs_unaligned,
	.ocn_realign_enable, .sync_sampling_precision, .ext_sync_sample, .ext_sync_fall
);

`default_nettype wire

// file: dv/sync_sink_model.sv
// Downstream sink model: measures the high time of each sync output.
// Assumes outputs synchronous to clk; widths counted in clk cycles.
`timescale 1ns/1ps
`default_nettype none

module sync_sink_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sync inputs from the device
	input wire logic frame_in,
	input wire logic mf_in,
	// Last completed high widths
	output logic [15:0] w8,
	output logic [15:0] w2
);
	logic [15:0] run8_r;
	logic [15:0] run2_r;

	// ==========================================================
	// High-time counters, width latched on each fall
	always_ff @(posedge clk) begin
		if (rst) begin
			run8_r <= 16'h0000;
			run2_r <= 16'h0000;
			w8 <= 16'h0000;
			w2 <= 16'h0000;
		end else begin
			run8_r <= frame_in ? run8_r + 16'h0001 : 16'h0000;
			run2_r <= mf_in ? run2_r + 16'h0001 : 16'h0000;
			if (!frame_in && run8_r != 16'h0000)
				w8 <= run8_r;
			if (!mf_in && run2_r != 16'h0000)
				w2 <= run2_r;
		end
	end
endmodule

`default_nettype wire

// file: rtl/frame_sync_pulse_config.sv
// Frame and multiframe sync output configuration with an APB register port.
// Assumes DPLL square waves, the width reference clock level and the
// external sync sampling strobes are all synchronous to clk.
//
// Contract
// - Sync outputs come from secondary DPLL when source bit set, else primary.
// - Frame output inverts on its flip bit; pulsed or 50:50 by shape bit.
// - Multiframe output inverts on its flip bit; pulsed or 50:50 by shape bit.
// - Frame pulse lasts one width reference period; reference must be enabled.
// - Multiframe pulse lasts one width reference period; reference must be enabled.
// - Sync outputs follow other output clock alignment unless independence bit set.
// - Fine bit clear: OC-N clocks untouched, external sync sampled at 6.48 MHz.
// - Fine bit set: 19.44 MHz precision with 19.44 reference, else 38.88.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "frame_sync_consts.svh"

module frame_sync_pulse_config (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// DPLL sync sources
	input wire frame_sync_pkg::dpll_sync_s primary_dpll_sync,
	input wire frame_sync_pkg::dpll_sync_s secondary_dpll_sync,
	// Width reference output clock
	input wire logic width_reference_output,
	input wire logic width_ref_enabled,
	// External multiframe sync input and sampling strobes
	input wire logic external_multiframe_sync_input,
	input wire logic ref_is_19m44,
	input wire logic sample_tick_6m48,
	input wire logic sample_tick_19m44,
	input wire logic sample_tick_38m88,
	// Sync outputs
	output logic frame_sync_output,
	output logic multiframe_sync_output,
	// Alignment controls toward the other output generators
	output logic sync_outputs_unaligned,
	output logic ocn_realign_enable,
	output frame_sync_pkg::sampling_precision_e sync_sampling_precision,
	// External sync sample results
	output logic ext_sync_sample,
	output logic ext_sync_fall
);

	// ==========================================================
	// Address decode shared by read and write paths
	function automatic logic is_reg(input logic [11:0] addr, input logic [9:0] idx);
		is_reg = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
	endfunction

	logic [7:0] sync_pulse_config_r;
	logic [7:0] sync_alignment_config_r;
	logic [7:0] sync_status;
	logic setup;
	logic access_done;
	logic hit_pulse;
	logic hit_align;
	logic hit_status;
	logic [31:0] rd_mux;

	assign setup = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign hit_pulse = is_reg(paddr, `IDX_SYNC_PULSE_CFG);
	assign hit_align = is_reg(paddr, `IDX_SYNC_ALIGN_CFG);
	assign hit_status = is_reg(paddr, `IDX_SYNC_STATUS);

	// ==========================================================
	// APB handshake: one wait-free access phase after each setup
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Error flagged for any address outside the three words
	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= ~(hit_pulse | hit_align | hit_status);
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Read data captured in setup so it stands through the access phase
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_pulse) begin
			rd_mux = {24'h00_0000, sync_pulse_config_r};
		end else if (hit_align) begin
			rd_mux = {24'h00_0000, sync_alignment_config_r};
		end else if (hit_status) begin
			rd_mux = {24'h00_0000, sync_status};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// ==========================================================
	// Configuration registers; masking keeps unused bits at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_pulse_config_r <= `RST_SYNC_PULSE_CFG;
		end else if (access_done && pwrite && hit_pulse) begin
			sync_pulse_config_r <= pwdata[7:0] & `MASK_SYNC_PULSE_CFG;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_alignment_config_r <= `RST_SYNC_ALIGN_CFG;
		end else if (access_done && pwrite && hit_align) begin
			sync_alignment_config_r <= pwdata[7:0] & `MASK_SYNC_ALIGN_CFG;
		end
	end

	// ==========================================================
	// Width reference edge detect and period measurement
	logic ref_d_r;
	logic ref_rise;
	logic [15:0] ref_cnt_r;
	logic [15:0] ref_period_r;
	logic [1:0] ref_edges_r;
	logic ref_ok;

	assign ref_rise = width_reference_output & ~ref_d_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			ref_d_r <= 1'b0;
		end else begin
			ref_d_r <= width_reference_output;
		end
	end

	// Saturating cycle count since the last rising edge
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_cnt_r <= 16'h0000;
		end else if (ref_rise) begin
			ref_cnt_r <= 16'h0001;
		end else if (ref_cnt_r != `REF_CNT_MAX) begin
			ref_cnt_r <= ref_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ref_period_r <= 16'h0000;
		end else if (ref_rise) begin
			ref_period_r <= ref_cnt_r;
		end
	end

	// A stalled reference invalidates the period so no pulse is stretched
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_edges_r <= 2'b00;
		end else if (!width_ref_enabled || ref_cnt_r == `REF_CNT_MAX) begin
			ref_edges_r <= 2'b00;
		end else if (ref_rise && ref_edges_r != 2'b11) begin
			ref_edges_r <= ref_edges_r + 2'b01;
		end
	end

	// Pulsed mode needs an enabled, measured reference
	assign ref_ok = width_ref_enabled && (ref_edges_r == 2'b11);

	// ==========================================================
	// Source selection between the two DPLLs
	frame_sync_pkg::dpll_sync_s src_sel;
	logic [1:0] src_lvl;
	logic [1:0] flip;
	logic [1:0] pulsed;
	logic [1:0] sync_q;

	assign src_sel = sync_pulse_config_r[`BIT_ALT_DPLL] ?
		secondary_dpll_sync : primary_dpll_sync;

	// Index 0 is the frame output, index 1 the multiframe output
	assign src_lvl[0] = src_sel.sq_8k;
	assign src_lvl[1] = src_sel.sq_2k;
	assign flip[0] = sync_pulse_config_r[`BIT_FRAME_FLIP];
	assign flip[1] = sync_pulse_config_r[`BIT_MF_FLIP];
	assign pulsed[0] = sync_pulse_config_r[`BIT_FRAME_SHAPE];
	assign pulsed[1] = sync_pulse_config_r[`BIT_MF_SHAPE];

	// ==========================================================
	// One shaper per sync output
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_shape
			sync_pulse_shaper u_shape (
				.clk(clk),
				.rst(rst),
				.src_level(src_lvl[gi]),
				.flip(flip[gi]),
				.pulsed(pulsed[gi]),
				.unaligned(sync_alignment_config_r[`BIT_UNALIGNED]),
				.ref_rise(ref_rise),
				.ref_ok(ref_ok),
				.ref_period(ref_period_r),
				.sync_out(sync_q[gi])
			);
		end
	endgenerate

	// Width of each pulse is one measured reference period
	assign frame_sync_output = sync_q[0];
	assign multiframe_sync_output = sync_q[1];

	// ==========================================================
	// Alignment controls to the other output generators
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_outputs_unaligned <= 1'b0;
		end else begin
			sync_outputs_unaligned <= sync_alignment_config_r[`BIT_UNALIGNED];
		end
	end

	// OC-N clocks only follow the external sync with fine sampling on
	always_ff @(posedge clk) begin
		if (rst) begin
			ocn_realign_enable <= 1'b0;
		end else begin
			ocn_realign_enable <= sync_alignment_config_r[`BIT_FINE_SAMPLING];
		end
	end

	// ==========================================================
	// Sampling precision choice for the external sync input
	frame_sync_pkg::sampling_precision_e prec_nxt;
	logic tick_sel;

	always_comb begin
		if (!sync_alignment_config_r[`BIT_FINE_SAMPLING]) begin
			prec_nxt = frame_sync_pkg::PREC_6M48;
		end else if (ref_is_19m44) begin
			prec_nxt = frame_sync_pkg::PREC_19M44;
		end else begin
			prec_nxt = frame_sync_pkg::PREC_38M88;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_sampling_precision <= frame_sync_pkg::PREC_6M48;
		end else begin
			sync_sampling_precision <= prec_nxt;
		end
	end

	// Strobe follows the applied precision, so a change takes one cycle
	always_comb begin
		case (sync_sampling_precision)
			frame_sync_pkg::PREC_6M48: tick_sel = sample_tick_6m48;
			frame_sync_pkg::PREC_19M44: tick_sel = sample_tick_19m44;
			frame_sync_pkg::PREC_38M88: tick_sel = sample_tick_38m88;
			default: tick_sel = 1'b0;
		endcase
	end

	// ==========================================================
	// External sync sample and falling-edge event
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_sync_sample <= 1'b0;
		end else if (tick_sel) begin
			ext_sync_sample <= external_multiframe_sync_input;
		end
	end

	// Falling edge is the alignment point, so flag it at the sample
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_sync_fall <= 1'b0;
		end else begin
			ext_sync_fall <= tick_sel & ext_sync_sample & ~external_multiframe_sync_input;
		end
	end

	// ==========================================================
	// Read-only status word
	always_comb begin
		sync_status = 8'h00;
		sync_status[`BIT_ST_REF_OK] = ref_ok;
		sync_status[`BIT_ST_EXT_SAMPLE] = ext_sync_sample;
		sync_status[`POS_ST_PRECISION +: 2] = sync_sampling_precision;
		sync_status[`BIT_ST_FRAME_OUT] = sync_q[0];
		sync_status[`BIT_ST_MF_OUT] = sync_q[1];
	end

endmodule

`default_nettype wire

// file: rtl/sync_pulse_shaper.sv
// One sync output: 50:50 square or single pulse, with optional inversion.
// Assumes src_level is a square wave synchronous to clk and that the
// width reference rising-edge strobe and measured period come from above.
`timescale 1ns/1ps
`default_nettype none

module sync_pulse_shaper (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Source and controls
	input wire logic src_level,
	input wire logic flip,
	input wire logic pulsed,
	input wire logic unaligned,
	// Width reference
	input wire logic ref_rise,
	input wire logic ref_ok,
	input wire logic [15:0] ref_period,
	// Result
	output logic sync_out
);

	frame_sync_pkg::shaper_state_e state_r;
	frame_sync_pkg::shaper_state_e state_nxt;
	logic src_d_r;
	logic sq_r;
	logic [15:0] cnt_r;
	logic src_rise;

	assign src_rise = src_level & ~src_d_r;

	// ==========================================================
	// Source edge history
	always_ff @(posedge clk) begin
		if (rst) begin
			src_d_r <= 1'b0;
		end else begin
			src_d_r <= src_level;
		end
	end

	// Square wave, retimed to the reference unless running independent
	always_ff @(posedge clk) begin
		if (rst) begin
			sq_r <= 1'b0;
		end else if (unaligned || ref_rise) begin
			sq_r <= src_level;
		end
	end

	// Pulse sequencing; a dead reference aborts any pulse in flight
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			frame_sync_pkg::SHP_IDLE: begin
				if (src_rise) begin
					state_nxt = unaligned ? frame_sync_pkg::SHP_HIGH : frame_sync_pkg::SHP_ARM;
				end
			end
			frame_sync_pkg::SHP_ARM: begin
				if (ref_rise) begin
					state_nxt = frame_sync_pkg::SHP_HIGH;
				end
			end
			frame_sync_pkg::SHP_HIGH: begin
				if (unaligned ? (cnt_r <= 16'h0001) : ref_rise) begin
					state_nxt = frame_sync_pkg::SHP_IDLE;
				end
			end
			default: state_nxt = frame_sync_pkg::SHP_IDLE;
		endcase
		if (!pulsed || !ref_ok) begin
			state_nxt = frame_sync_pkg::SHP_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= frame_sync_pkg::SHP_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Width counter for independent pulses, one reference period long
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= 16'h0000;
		end else if (state_r != frame_sync_pkg::SHP_HIGH) begin
			cnt_r <= ref_period;
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	// Registered output with polarity applied last
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_out <= 1'b0;
		end else if (pulsed) begin
			sync_out <= flip ^ (state_nxt == frame_sync_pkg::SHP_HIGH);
		end else begin
			sync_out <= flip ^ sq_r;
		end
	end

endmodule

`default_nettype wire

// file: shared/frame_sync_consts.svh
// Constants for the frame and multiframe sync configuration block.
// Assumes inclusion by bare name from files under rtl/ and dv/.
`ifndef FRAME_SYNC_CONSTS_SVH
`define FRAME_SYNC_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_SYNC_PULSE_CFG 10'h07A
`define IDX_SYNC_ALIGN_CFG 10'h07B
`define IDX_SYNC_STATUS 10'h07C

// ==========================================================
// Reset values
`define RST_SYNC_PULSE_CFG 8'h00
`define RST_SYNC_ALIGN_CFG 8'h00

// ==========================================================
// Field positions, pulse configuration
`define BIT_ALT_DPLL 7
`define BIT_FRAME_FLIP 3
`define BIT_FRAME_SHAPE 2
`define BIT_MF_FLIP 1
`define BIT_MF_SHAPE 0
`define MASK_SYNC_PULSE_CFG 8'h8F

// ==========================================================
// Field positions, alignment configuration
`define BIT_UNALIGNED 7
`define BIT_FINE_SAMPLING 6
`define MASK_SYNC_ALIGN_CFG 8'hC0

// ==========================================================
// Field positions, status
`define BIT_ST_REF_OK 0
`define BIT_ST_EXT_SAMPLE 1
`define POS_ST_PRECISION 2
`define BIT_ST_FRAME_OUT 4
`define BIT_ST_MF_OUT 5

// ==========================================================
// Width reference period measurement
`define REF_CNT_W 16
`define REF_CNT_MAX 16'hFFFF

`endif

// file: shared/frame_sync_pkg.sv
// Types shared by the sync configuration block and its pulse shaper.
// Assumes the constants header sits beside it under shared/.
`default_nettype none

package frame_sync_pkg;

	// ==========================================================
	// Square-wave sync levels from one DPLL
	typedef struct packed {
		logic sq_8k;
		logic sq_2k;
	} dpll_sync_s;

	// ==========================================================
	// External sync sampling precision
	typedef enum logic [1:0] {
		PREC_6M48 = 2'b00,
		PREC_19M44 = 2'b01,
		PREC_38M88 = 2'b10
	} sampling_precision_e;

	// ==========================================================
	// Pulse shaper states
	typedef enum logic [1:0] {
		SHP_IDLE = 2'b00,
		SHP_ARM = 2'b01,
		SHP_HIGH = 2'b10
	} shaper_state_e;

endpackage

`default_nettype wire
